/* verilog/lsc_pkg.sv */
// Overview of operation
// RULE1: Codes 0060..006F select reported counter values; the code reports only 0060..0068, and 0069..006F read as invalid with zero
// RULE2: SDLC/X.21: 0060 counts test frames failing CRC
// RULE3: X.25: 0060 counts RNR commands sent
// RULE4: SDLC/X.21: 0061 counts good test frames
// RULE5: X.25: 0061 counts RNR commands received
// RULE6: 0062 counts transmit underruns
// RULE7: 0063 counts receive overruns
// RULE8: 0064 counts carrier loss with frame error
// RULE9: 0065 counts send-ready loss with host error
// RULE10: 0066 counts ready loss over two bits
// RULE11: SDLC/X.21: 0067 counts frame sequence errors
// RULE12: X.25: 0067 counts REJ commands sent
// RULE13: SDLC/X.21: 0068 counts retransmission events once
// RULE14: Counters clear on reset and saturate
package lsc_pkg;
   // ----------------------------------------
   // Reporting codes
   // ----------------------------------------
   localparam logic [15:0] CODE_FIRST = 16'h0060;
   localparam logic [15:0] CODE_LAST = 16'h006F;
   localparam logic [15:0] CODE_TEST_BAD = 16'h0060;
   localparam logic [15:0] CODE_TEST_GOOD = 16'h0061;
   localparam logic [15:0] CODE_UNDERRUN = 16'h0062;
   localparam logic [15:0] CODE_OVERRUN = 16'h0063;
   localparam logic [15:0] CODE_CARRIER = 16'h0064;
   localparam logic [15:0] CODE_SEND_READY = 16'h0065;
   localparam logic [15:0] CODE_DSR = 16'h0066;
   localparam logic [15:0] CODE_SEQ = 16'h0067;
   localparam logic [15:0] CODE_RETRY = 16'h0068;
   // ----------------------------------------
   // Counter layout and timing
   // ----------------------------------------
   localparam int NUM_COUNTERS = 9;
   localparam int CNT_WIDTH = 16;
   localparam int LOSS_BIT_TIMES = 2;
   localparam logic [15:0] BIT_DIV_RESET = 16'h0000;
   localparam logic [15:0] BIT_DIV_CYCLES = 16'h0014; // Clocks per link bit time
   typedef enum {LSC_SDLC, LSC_X25} lsc_mode_t;
endpackage

/* verilog/lsc_loss_det.sv */
`timescale 1ns/1ns
`default_nettype none
// Pulses once when a synchronised active-high line has been low for a set
// number of bit-time enables while armed.
module lsc_loss_det #(
   parameter int BITS = 2,
   parameter bit STRICT = 1'b0
) (
   // Clock and reset
   input wire logic i_ref_clk,
   input wire logic i_reset_n,
   // Line and timing
   input wire logic i_bit_en,
   input wire logic i_arm,
   input wire logic i_pin,
   // Result
   output logic o_lost
);
   logic [1:0] sync_a;
   logic sync_b;
   logic line;
   logic [3:0] low_cnt;
   logic [3:0] next_low_cnt;
   logic next_line;
   logic next_lost;
   localparam logic [3:0] LIMIT = 4'(STRICT ? BITS + 1 : BITS);

   // Three flops; change taken when second and third agree
   always_comb begin
      next_line = (sync_a[1] == sync_b) ? sync_b : line;
      next_low_cnt = low_cnt;
      next_lost = 1'b0;
      if (!i_arm || line) begin
         next_low_cnt = 4'h0;
      end else if (i_bit_en && low_cnt != LIMIT) begin
         next_low_cnt = low_cnt + 4'h1;
         next_lost = (low_cnt + 4'h1) == LIMIT;
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         sync_a <= 2'h3; // Idle level, so no false drop after reset
         sync_b <= 1'b1;
         line <= 1'b1;
         low_cnt <= 4'h0;
         o_lost <= 1'b0;
      end else begin
         sync_a <= {sync_a[0], i_pin};
         sync_b <= sync_a[1];
         line <= next_line;
         low_cnt <= next_low_cnt;
         o_lost <= next_lost;
      end
   end
endmodule
`default_nettype wire

/* verilog/lsc_counters.sv */
`timescale 1ns/1ns
`default_nettype none
module lsc_counters #(
   parameter int WIDTH = lsc_pkg::CNT_WIDTH,
   parameter logic [15:0] BIT_DIV = lsc_pkg::BIT_DIV_CYCLES
) (
   // Clock and reset
   input wire logic i_ref_clk,
   input wire logic i_reset_n,
   // Configuration
   input wire logic i_mode_x25,
   input wire logic i_switched,
   // Link events, one-cycle pulses
   input wire logic i_test_crc_bad,
   input wire logic i_test_good,
   input wire logic i_rnr_sent,
   input wire logic i_rnr_rcvd,
   input wire logic i_underrun,
   input wire logic i_overrun,
   input wire logic i_seq_error,
   input wire logic i_rej_sent,
   input wire logic i_retry_start,
   input wire logic i_rx_frame_end,
   input wire logic i_rx_frame_err,
   input wire logic i_host_resp,
   input wire logic i_host_resp_err,
   // Activity and line pins
   input wire logic i_rx_active,
   input wire logic i_tx_active,
   input wire logic i_carrier,
   input wire logic i_ready_for_sending_input,
   input wire logic i_dsr,
   // Report port
   input wire logic [15:0] i_system_reference_code,
   output logic [WIDTH-1:0] o_count,
   output logic o_code_valid
);
   logic [WIDTH-1:0] cnt [lsc_pkg::NUM_COUNTERS];
   logic [WIDTH-1:0] next_cnt [lsc_pkg::NUM_COUNTERS];
   logic [lsc_pkg::NUM_COUNTERS-1:0] inc;
   logic [15:0] div;
   logic [15:0] next_div;
   logic bit_en;
   logic carrier_lost, send_ready_lost, dsr_lost;
   logic carrier_flag, send_ready_flag;
   logic next_carrier_flag, next_send_ready_flag;
   logic [WIDTH-1:0] next_count;
   logic next_code_valid;
   lsc_pkg::lsc_mode_t mode;

   // ----------------------------------------
   // Bit-time enable divider
   // ----------------------------------------
   always_comb begin
      next_div = (div == BIT_DIV - 16'h0001) ? lsc_pkg::BIT_DIV_RESET : div + 16'h0001;
   end
   assign bit_en = (div == BIT_DIV - 16'h0001);
   assign mode = i_mode_x25 ? lsc_pkg::LSC_X25 : lsc_pkg::LSC_SDLC;

   // Line loss detectors
   lsc_loss_det #(.BITS(lsc_pkg::LOSS_BIT_TIMES), .STRICT(1'b0)) u_carrier (
      .i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n), .i_bit_en(bit_en),
      .i_arm(i_rx_active), .i_pin(i_carrier), .o_lost(carrier_lost));
   lsc_loss_det #(.BITS(lsc_pkg::LOSS_BIT_TIMES), .STRICT(1'b0)) u_send_ready (
      .i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n), .i_bit_en(bit_en),
      .i_arm(i_tx_active), .i_pin(i_ready_for_sending_input), .o_lost(send_ready_lost));
   lsc_loss_det #(.BITS(lsc_pkg::LOSS_BIT_TIMES), .STRICT(1'b1)) u_dsr (
      .i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n), .i_bit_en(bit_en),
      .i_arm(!i_switched), .i_pin(i_dsr), .o_lost(dsr_lost)); // RULE10

   // ----------------------------------------
   // Pending loss flags, judged at frame end or host reply
   // ----------------------------------------
   always_comb begin
      next_carrier_flag = carrier_flag;
      next_send_ready_flag = send_ready_flag;
      if (i_rx_frame_end) begin
         next_carrier_flag = 1'b0;
      end
      if (carrier_lost) begin
         next_carrier_flag = 1'b1;
      end
      if (i_host_resp) begin
         next_send_ready_flag = 1'b0;
      end
      if (send_ready_lost) begin
         next_send_ready_flag = 1'b1;
      end
   end

   // Event select per counter
   always_comb begin
      inc = '0;
      case (mode)
         lsc_pkg::LSC_X25: begin
            inc[0] = i_rnr_sent; // RULE3
            inc[1] = i_rnr_rcvd; // RULE5
            inc[7] = i_rej_sent; // RULE12
         end
         default: begin
            inc[0] = i_test_crc_bad; // RULE2
            inc[1] = i_test_good; // RULE4
            inc[7] = i_seq_error; // RULE11
            inc[8] = i_retry_start; // RULE13
         end
      endcase
      inc[2] = i_underrun; // RULE6
      inc[3] = i_overrun; // RULE7
      inc[4] = i_rx_frame_end && i_rx_frame_err && (carrier_flag || carrier_lost); // RULE8
      inc[5] = i_host_resp && i_host_resp_err && (send_ready_flag || send_ready_lost); // RULE9
      inc[6] = dsr_lost; // RULE10
   end

   // Saturating counters
   generate
      for (genvar g = 0; g < lsc_pkg::NUM_COUNTERS; g++) begin : g_cnt
         always_comb begin
            next_cnt[g] = (inc[g] && cnt[g] != '1) ? cnt[g] + 1'b1 : cnt[g]; // RULE14
         end
      end
   endgenerate

   // ----------------------------------------
   // Report mux
   // ----------------------------------------
   always_comb begin
      next_count = '0;
      next_code_valid = 1'b0;
      if (i_system_reference_code >= lsc_pkg::CODE_FIRST &&
          i_system_reference_code <= lsc_pkg::CODE_RETRY) begin
         next_code_valid = 1'b1; // RULE1
         next_count = cnt[4'(i_system_reference_code - lsc_pkg::CODE_FIRST)]; // RULE1
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         div <= lsc_pkg::BIT_DIV_RESET;
         carrier_flag <= 1'b0;
         send_ready_flag <= 1'b0;
         o_count <= '0;
         o_code_valid <= 1'b0;
         for (int k = 0; k < lsc_pkg::NUM_COUNTERS; k++) begin
            cnt[k] <= '0; // RULE14
         end
      end else begin
         div <= next_div;
         carrier_flag <= next_carrier_flag;
         send_ready_flag <= next_send_ready_flag;
         o_count <= next_count;
         o_code_valid <= next_code_valid;
         for (int k = 0; k < lsc_pkg::NUM_COUNTERS; k++) begin
            cnt[k] <= next_cnt[k];
         end
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   chk_underrun_count: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n) // RULE6
      i_underrun && cnt[2] != '1 |=> cnt[2] == $past(cnt[2]) + 1'b1)
      else $error("underrun count missed");
   chk_overrun_count: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n) // RULE7
      !i_overrun |=> cnt[3] == $past(cnt[3]))
      else $error("overrun count moved");
   chk_rnr_sent: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n) // RULE3
      i_mode_x25 && i_rnr_sent && !i_test_crc_bad && cnt[0] != '1
      |=> cnt[0] != $past(cnt[0]))
      else $error("rnr sent not counted");
   chk_test_bad: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n) // RULE2
      !i_mode_x25 && i_rnr_sent && !i_test_crc_bad |=> $stable(cnt[0]))
      else $error("rnr counted in sdlc mode");
   chk_test_good: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n) // RULE4
      !i_mode_x25 && i_test_good && cnt[1] != '1 |=> cnt[1] == $past(cnt[1]) + 1'b1)
      else $error("good test frame missed");
   chk_rnr_rcvd: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n) // RULE5
      i_mode_x25 && i_rnr_rcvd && cnt[1] != '1 |=> cnt[1] == $past(cnt[1]) + 1'b1)
      else $error("rnr received missed");
   chk_carrier_err: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n) // RULE8
      !i_rx_frame_err |=> $stable(cnt[4]))
      else $error("carrier count without frame error");
   chk_send_ready_err: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n) // RULE9
      !(i_host_resp && i_host_resp_err) |=> $stable(cnt[5]))
      else $error("send ready count without host error");
   chk_dsr_switched: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n) // RULE10
      i_switched [*4] |=> $stable(cnt[6]))
      else $error("dsr counted on switched line");
   chk_seq_count: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n) // RULE11
      !i_mode_x25 && i_seq_error && cnt[7] != '1 |=> cnt[7] == $past(cnt[7]) + 1'b1)
      else $error("sequence error missed");
   chk_rej_count: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n) // RULE12
      i_mode_x25 && i_rej_sent && cnt[7] != '1 |=> cnt[7] == $past(cnt[7]) + 1'b1)
      else $error("rej sent missed");
   chk_retry_x25: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n) // RULE13
      i_mode_x25 |=> $stable(cnt[8]))
      else $error("retry counted in x25 mode");
   chk_saturate: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n) // RULE14
      cnt[2] == '1 |=> cnt[2] == '1)
      else $error("counter wrapped");
   chk_report_valid: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n) // RULE1
      i_system_reference_code == lsc_pkg::CODE_UNDERRUN |=> o_code_valid
      && o_count == $past(cnt[2]))
      else $error("report value wrong");
   // Counting paths that the checks above only guard from one side
   chk_test_bad_count: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n) // RULE2
      !i_mode_x25 && i_test_crc_bad && cnt[0] != '1 |=> cnt[0] == $past(cnt[0]) + 1'b1)
      else $error("bad test frame missed");
   chk_overrun_inc: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n) // RULE7
      i_overrun && cnt[3] != '1 |=> cnt[3] == $past(cnt[3]) + 1'b1)
      else $error("overrun missed");
   chk_carrier_count: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n) // RULE8
      i_rx_frame_end && i_rx_frame_err && carrier_flag && cnt[4] != '1
      |=> cnt[4] == $past(cnt[4]) + 1'b1)
      else $error("carrier loss missed");
   chk_send_ready_count: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n) // RULE9
      i_host_resp && i_host_resp_err && send_ready_flag && cnt[5] != '1
      |=> cnt[5] == $past(cnt[5]) + 1'b1)
      else $error("send ready loss missed");
   chk_dsr_count: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n) // RULE10
      dsr_lost && cnt[6] != '1 |=> cnt[6] == $past(cnt[6]) + 1'b1)
      else $error("dsr loss missed");
   chk_retry_count: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n) // RULE13
      !i_mode_x25 && i_retry_start && cnt[8] != '1 |=> cnt[8] == $past(cnt[8]) + 1'b1)
      else $error("retry event missed");
   chk_report_range: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n) // RULE1
      i_system_reference_code > lsc_pkg::CODE_RETRY |=> !o_code_valid && o_count == '0)
      else $error("unused code reported");
endmodule
`default_nettype wire

/* verif/lsc_line_model.sv */
`timescale 1ns/1ns
`default_nettype none
// Line side of the link: holds one of three pins low for a number of bit times
module lsc_line_model #(
   parameter int BIT_DIV = 4
) (
   // Clock and reset
   input wire logic i_ref_clk,
   input wire logic i_reset_n,
   // Drop request
   input wire logic i_start,
   input wire logic [1:0] i_sel,
   input wire logic [7:0] i_bits,
   // Line pins, active high
   output logic o_carrier,
   output logic o_send_ready,
   output logic o_dsr,
   output logic o_busy
);
   logic [15:0] left;
   logic [1:0] sel;
   // Drop timer, a new drop only once the last one is over
   always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         left <= 16'h0000;
         sel <= 2'h0;
      end else if (i_start && left == 16'h0000) begin
         left <= 16'(i_bits * BIT_DIV);
         sel <= i_sel;
      end else if (left != 16'h0000) begin
         left <= left - 16'h0001;
      end
   end
   // Pins idle high, the selected one low while the timer runs
   assign o_busy = (left != 16'h0000);
   assign o_carrier = !(o_busy && sel == 2'h0);
   assign o_send_ready = !(o_busy && sel == 2'h1);
   assign o_dsr = !(o_busy && sel == 2'h2);
endmodule
`default_nettype wire

/* verif/tb.sv */
`timescale 1ns/1ns
`default_nettype none
module tb;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic x25 = 1'b0;
   logic sw = 1'b0;
   logic rx_act = 1'b0;
   logic tx_act = 1'b0;
   logic [12:0] ev = 13'h0000;
   logic [15:0] code = 16'h0000;
   logic start = 1'b0;
   logic [1:0] sel = 2'h0;
   logic car, send_rdy, dsr, busy, valid;
   logic [3:0] cnt;
   int errors = 0;
   int n_compared = 0;
   // ----------------------------------------
   // Clock and instances
   // ----------------------------------------
   always #20 clk = ~clk;
   lsc_line_model #(.BIT_DIV(4)) lsc_line_model_inst (.i_ref_clk(clk), .i_reset_n(rst_n),
      .i_start(start), .i_sel(sel), .i_bits(8'h05), .o_carrier(car), .o_send_ready(send_rdy),
      .o_dsr(dsr), .o_busy(busy));
   lsc_counters #(.WIDTH(4), .BIT_DIV(16'h0004)) lsc_counters_inst (.i_ref_clk(clk),
      .i_reset_n(rst_n), .i_mode_x25(x25), .i_switched(sw), .i_test_crc_bad(ev[0]),
      .i_test_good(ev[1]), .i_rnr_sent(ev[2]), .i_rnr_rcvd(ev[3]), .i_underrun(ev[4]),
      .i_overrun(ev[5]), .i_seq_error(ev[6]), .i_rej_sent(ev[7]), .i_retry_start(ev[8]),
      .i_rx_frame_end(ev[9]), .i_rx_frame_err(ev[10]), .i_host_resp(ev[11]),
      .i_host_resp_err(ev[12]), .i_rx_active(rx_act), .i_tx_active(tx_act),
      .i_carrier(car), .i_ready_for_sending_input(send_rdy), .i_dsr(dsr),
      .i_system_reference_code(code), .o_count(cnt), .o_code_valid(valid));
   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task print_verdict;
      $display("compared %0d errors %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   task chk(input string name, input logic [15:0] exp, input logic [15:0] got);
      n_compared++;
      if (got !== exp) begin
         errors++;
         $display("ERROR %s expected %h seen %h", name, exp, got);
      end
   endtask
   task do_reset;
      rst_n = 1'b0;
      repeat (3) @(negedge clk);
      rst_n = 1'b1;
   endtask
   // Holds the event mask high for n rising edges
   task pulse(input logic [12:0] mask, input int n);
      @(negedge clk);
      ev = mask;
      repeat (n) @(negedge clk);
      ev = 13'h0000;
   endtask
   task read(input logic [15:0] c);
      @(negedge clk);
      code = c;
      repeat (2) @(negedge clk);
   endtask
   // One drop of the selected pin, then waits until it is back and settled
   task drop_line(input logic [1:0] s);
      int k;
      sel = s;
      start = 1'b1;
      @(negedge clk);
      start = 1'b0;
      @(negedge clk);
      k = 0;
      while (busy && k < 100) begin
         @(negedge clk);
         k++;
      end
      if (k >= 100) begin
         chk("drop ended", 16'h0000, {15'h0000, busy});
         print_verdict;
      end
      repeat (8) @(negedge clk);
   endtask
   function automatic int dest(input logic m, input int b);
      case (b)
         0: return m ? -1 : 0;
         1: return m ? -1 : 1;
         2: return m ? 0 : -1;
         3: return m ? 1 : -1;
         4: return 2;
         5: return 3;
         6: return m ? -1 : 7;
         7: return m ? 7 : -1;
         8: return m ? -1 : 8;
         default: return -1;
      endcase
   endfunction
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task reset_codes;
      do_reset;
      for (int i = 0; i < 16; i++) begin
         read(16'h0060 + 16'(i));
         chk("count", 16'h0000, {12'h000, cnt});
         chk("valid", (i < 9) ? 16'h0001 : 16'h0000, {15'h0000, valid});
      end
   endtask
   // Event i pulsed i+1 times back to back, then codes 0060..0069 and 0070 read back
   task mode_counts(input logic m);
      int exp [9];
      do_reset;
      x25 = m;
      for (int c = 0; c < 9; c++) exp[c] = 0;
      for (int b = 0; b < 9; b++) begin
         pulse(13'h0001 << b, b + 1);
         if (dest(m, b) >= 0) exp[dest(m, b)] = b + 1;
      end
      for (int c = 0; c < 9; c++) begin
         read(16'h0060 + 16'(c));
         chk("mode count", 16'(exp[c]), {12'h000, cnt});
         chk("mode valid", 16'h0001, {15'h0000, valid});
      end
      read(16'h0069);
      chk("code 0069", 16'h0000, {12'h000, cnt});
      chk("code 0069 valid", 16'h0000, {15'h0000, valid});
      read(16'h0070);
      chk("code 0070", 16'h0000, {12'h000, cnt});
      chk("code 0070 valid", 16'h0000, {15'h0000, valid});
      x25 = 1'b0;
   endtask
   task sat_check;
      do_reset;
      pulse(13'h0010, 20);
      read(16'h0062);
      chk("saturated", 16'h000F, {12'h000, cnt});
   endtask
   // Pin dropped five bit times, then qualifying event twice; one count only
   task line_loss(input logic [1:0] s, input logic [12:0] mask, input logic [15:0] c);
      do_reset;
      rx_act = 1'b1;
      tx_act = 1'b1;
      drop_line(s);
      pulse(mask, 1);
      read(c);
      chk("loss count", 16'h0001, {12'h000, cnt});
      pulse(mask, 1);
      read(c);
      chk("loss again", 16'h0001, {12'h000, cnt});
      rx_act = 1'b0;
      tx_act = 1'b0;
   endtask
   // Drop, then a clean frame end or reply clears it; a later error finds nothing
   task loss_cleared(input logic [1:0] s, input logic [12:0] done, input logic [12:0] bad,
                     input logic [15:0] c);
      do_reset;
      rx_act = 1'b1;
      tx_act = 1'b1;
      drop_line(s);
      pulse(done, 1);
      pulse(bad, 1);
      read(c);
      chk("loss cleared", 16'h0000, {12'h000, cnt});
      rx_act = 1'b0;
      tx_act = 1'b0;
   endtask
   // Drops with both paths idle and the line switched are never counted
   task loss_unarmed;
      do_reset;
      sw = 1'b1;
      drop_line(2'h0);
      drop_line(2'h1);
      drop_line(2'h2);
      pulse(13'h1E00, 1);
      for (int i = 4; i < 7; i++) begin
         read(16'h0060 + 16'(i));
         chk("unarmed loss", 16'h0000, {12'h000, cnt});
      end
      sw = 1'b0;
   endtask
   // Main sequence
   initial begin
      reset_codes;
      mode_counts(1'b0);
      mode_counts(1'b1);
      sat_check;
      line_loss(2'h0, 13'h0600, 16'h0064);
      line_loss(2'h1, 13'h1800, 16'h0065);
      line_loss(2'h2, 13'h0000, 16'h0066);
      loss_cleared(2'h0, 13'h0200, 13'h0600, 16'h0064);
      loss_cleared(2'h1, 13'h0800, 13'h1800, 16'h0065);
      loss_unarmed;
      print_verdict;
   end
endmodule
`default_nettype wire
